// ===== dv/rscl_strap_board.sv
// board side of the strap pins: pull resistors plus a reset-time driver
// assumes the bench holds cfg steady while rst_b is low
`timescale 1ns/1ps
`default_nettype none
module rscl_strap_board (
    input  wire logic [12:0] cfg,       // wanted image, pci, sp2, bad pull
    output logic      [9:0]  strapImg,  // strap levels
    output logic      [2:0]  rsvStraps, // reserved lines
    output logic             pciSel,    // pci enable
    output logic             sp2Sel     // port 2 enable, live
);
    // autoinit is never pulled up while pci is off
    assign strapImg  = {cfg[9:8], cfg[7] & cfg[10], cfg[6:0]};
    assign rsvStraps = cfg[12] ? 3'b111 : 3'b011;
    assign pciSel    = cfg[10];
    assign sp2Sel    = cfg[11];
endmodule // rscl_strap_board
`default_nettype wire

// ===== dv/rscl_strap_latch_properties.sv
// checker for the strap latch outputs and the mux register write
// assumes it is bound to rscl_strap_latch and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module rscl_strap_latch_properties #(
    parameter integer CAPTURE_CYCLES = 2
) (
    input wire logic        clk_sys,             // clock
    input wire logic        rst_b,               // reset
    input wire logic        serial_port2_select, // live pin
    input wire logic        hsel,                // select
    input wire logic [31:0] haddr,               // address
    input wire logic [1:0]  htrans,              // transfer
    input wire logic        hwrite,              // write
    input wire logic [31:0] hwdata,              // write data
    input wire logic        hready,              // ready
    input wire logic        bigEndian_q,         // endian
    input wire logic [1:0]  primaryClkSrc_q,     // clock a
    input wire logic [1:0]  secondaryClkSrc_q,   // clock b
    input wire logic        pciEepromLoad_q,     // eeprom load
    input wire logic        serialPort1En_q,     // port 1
    input wire logic        atmPortEn_q,         // atm
    input wire logic        serialPort2En_q,     // port 2
    input wire logic        hostPort32_q,        // width
    input wire logic        hostUpperOe_q,       // upper oe
    input wire logic [31:0] swMux_q              // mux reg
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    wire logic cap = serialPort1En_q || atmPortEn_q;
    property p_excl; !(serialPort1En_q && atmPortEn_q); endproperty
    a_excl: assert property (p_excl) else $error("both ports own shared pins");
    property p_hold; cap && $past(cap) |-> $stable({bigEndian_q, primaryClkSrc_q,
        secondaryClkSrc_q, hostPort32_q, atmPortEn_q}); endproperty
    a_hold: assert property (p_hold) else $error("captured setting moved");
    property p_upper; cap |-> hostUpperOe_q == hostPort32_q; endproperty
    a_upper: assert property (p_upper) else $error("upper lines oe wrong");
    property p_pclk; primaryClkSrc_q != 2'b11; endproperty
    a_pclk: assert property (p_pclk) else $error("primary clock code reserved");
    property p_sclk; secondaryClkSrc_q != 2'b11; endproperty
    a_sclk: assert property (p_sclk) else $error("secondary clock code reserved");
    property p_eeld; pciEepromLoad_q |-> !serialPort2En_q; endproperty
    a_eeld: assert property (p_eeld) else $error("eeprom load with port 2 on");
    property p_sp2; serial_port2_select [*4] ##0 cap |-> ##[0:2] serialPort2En_q; endproperty
    a_sp2: assert property (p_sp2) else $error("port 2 select not followed");
    property p_mux; hsel && htrans[1] && hwrite && hready && haddr[11:0] == 12'h00c ##1 1'b1
        |=> swMux_q == $past(hwdata); endproperty
    a_mux: assert property (p_mux) else $error("mux register not written");
    c_atm: cover property (atmPortEn_q);
    c_eeld: cover property (pciEepromLoad_q);
    c_eeoff: cover property ($fell(pciEepromLoad_q));
endmodule // rscl_strap_latch_properties
bind rscl_strap_latch rscl_strap_latch_properties #(.CAPTURE_CYCLES(CAPTURE_CYCLES))
    rscl_strap_latch_properties_i (.clk_sys(clk_sys), .rst_b(rst_b),
    .serial_port2_select(serial_port2_select), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .bigEndian_q(bigEndian_q),
    .primaryClkSrc_q(primaryClkSrc_q), .secondaryClkSrc_q(secondaryClkSrc_q),
    .pciEepromLoad_q(pciEepromLoad_q), .serialPort1En_q(serialPort1En_q),
    .atmPortEn_q(atmPortEn_q), .serialPort2En_q(serialPort2En_q),
    .hostPort32_q(hostPort32_q), .hostUpperOe_q(hostUpperOe_q), .swMux_q(swMux_q));
`default_nettype wire

// ===== dv/test_rscl_strap_latch.sv
// self-checking bench: strap decode per image, live pin changes, register access
// assumes the board model drives the straps and the bus is a single AHB-Lite master
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module test_rscl_strap_latch;
    logic        clk_sys, rst_b, hsel, hwrite, pciSel, sp2Sel, hreadyout, hresp;
    logic        bigEndian_q, bootEnable_q, pciEepromLoad_q, serialPort1En_q, atmPortEn_q;
    logic        serialPort2En_q, hostPort32_q, hostUpperOe_q;
    logic [1:0]  htrans, bootMode_q, primaryClkSrc_q, secondaryClkSrc_q;
    logic [2:0]  hsize, rsvStraps;
    logic [9:0]  strapImg;
    logic [12:0] cfg;
    logic [31:0] haddr, hwdata, hrdata, swMux_q, rd;
    int          failures = 0;
    int          compares = 0;
    rscl_strap_board rscl_strap_board_i (.cfg(cfg), .strapImg(strapImg),
        .rsvStraps(rsvStraps), .pciSel(pciSel), .sp2Sel(sp2Sel));
    rscl_strap_latch #(.CAPTURE_CYCLES(1)) rscl_strap_latch_i (.clk_sys(clk_sys), .rst_b(rst_b),
        .endian_select(strapImg[0]), .boot_select(strapImg[2:1]),
        .primary_mem_clock_select(strapImg[4:3]), .secondary_mem_clock_select(strapImg[6:5]),
        .eeprom_autoinit_select(strapImg[7]), .atm_port_select(strapImg[8]),
        .reserved_straps(rsvStraps), .host_width_strap(strapImg[9]), .pci_select(pciSel),
        .serial_port2_select(sp2Sel), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .bigEndian_q(bigEndian_q),
        .bootMode_q(bootMode_q), .bootEnable_q(bootEnable_q),
        .primaryClkSrc_q(primaryClkSrc_q), .secondaryClkSrc_q(secondaryClkSrc_q),
        .pciEepromLoad_q(pciEepromLoad_q), .serialPort1En_q(serialPort1En_q),
        .atmPortEn_q(atmPortEn_q), .serialPort2En_q(serialPort2En_q),
        .hostPort32_q(hostPort32_q), .hostUpperOe_q(hostUpperOe_q), .swMux_q(swMux_q));
    task automatic close_out;
        if (failures == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // entered just after a rising edge; waits stay open, the watchdog ends a hang
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'b10; hsize <= 3'b010;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic chk_out(input logic [12:0] c);
        `CHK(bigEndian_q, ~c[0])
        `CHK(({bootEnable_q, bootMode_q}), ({c[2:1] == 2'b01 || c[2:1] == 2'b10, c[2:1]}))
        `CHK(primaryClkSrc_q, (c[4:3] == 2'b11 ? 2'b00 : c[4:3]))
        `CHK(secondaryClkSrc_q, (c[6:5] == 2'b11 ? 2'b00 : c[6:5]))
        `CHK(pciEepromLoad_q, (c[7] & c[10] & ~c[11]))
        `CHK(({atmPortEn_q, serialPort1En_q}), ({c[8], ~c[8]}))
        `CHK(({hostPort32_q, hostUpperOe_q}), ({2{c[9]}}))
        `CHK(serialPort2En_q, (~c[10] | c[11]))
    endtask
    // image bits: 12 bad pull, 11 sp2, 10 pci, 9 width, 8 atm, 7 auto, 6:1 codes, 0 endian
    task automatic t_decode(input logic [12:0] c);
        logic [31:0] st;
        logic        a;
        a = c[7] & c[10];
        st = 32'h0;
        cfg <= c;
        rst_b <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        for (int i = 0; i < 40 && st[6] !== 1'b1; i++) bus(1'b0, 32'h8, 32'h0, st);
        // decoded outputs land one edge after the captured flag, so read once more
        bus(1'b0, 32'h8, 32'h0, st);
        `CHK(st[6:0], ({1'b1, c[12], ~c[10] | c[11], a & ~c[11], c[6:5] == 2'b11,
            c[4:3] == 2'b11, c[2:1] == 2'b11}))
        bus(1'b0, 32'h4, 32'h0, rd);
        `CHK(rd, ({28'h0, ~c[10] | c[11], c[10],
            c[2:1] == 2'b11 || c[4:3] == 2'b11 || c[6:5] == 2'b11, 1'b1}))
        bus(1'b0, 32'h0, 32'h0, rd);
        `CHK(rd, ({22'h0, c[9:8], a, c[6:0]}))
        chk_out(c);
        cfg <= c ^ 13'h13ff;
        repeat (8) @(posedge clk_sys);
        chk_out(c);
    endtask
    task automatic t_sp2;
        t_decode(13'h07ca);
        cfg <= 13'h0fca;
        repeat (8) @(posedge clk_sys);
        chk_out(13'h0fca);
    endtask
    task automatic t_regs;
        bus(1'b1, 32'hc, 32'ha5a55a5a, rd);
        bus(1'b0, 32'hc, 32'h0, rd);
        `CHK(rd, 32'ha5a55a5a)
        bus(1'b1, 32'h0, 32'hffffffff, rd);
        bus(1'b0, 32'h0, 32'h0, rd);
        `CHK(rd, 32'h00000005)
        bus(1'b0, 32'h10, 32'h0, rd);
        `CHK(({hresp, rd}), 33'h0)
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        #100000;
        failures++;
        close_out;
    end
    initial begin
        rst_b = 1'b0; cfg = 13'h0005; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00;
        hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0;
        // t_decode keeps reset low for three more edges, eight in all
        repeat (5) @(posedge clk_sys);
        t_decode(13'h0005);
        t_regs;
        t_decode(13'h10f8);
        t_decode(13'h0cb7);
        t_sp2;
        close_out;
    end
endmodule // test_rscl_strap_latch
`default_nettype wire

// ===== rtl/rscl_regs.vh
// register offsets, field positions and reset values for the strap latch
// assumes AHB-Lite word access, byte addresses
`ifndef RSCL_REGS_VH
`define RSCL_REGS_VH
`define RSCL_OFF_STRAP      12'h000
`define RSCL_OFF_PINSEL     12'h004
`define RSCL_OFF_STATUS     12'h008
`define RSCL_OFF_SWMUX      12'h00c
// strap register field positions
`define RSCL_F_ENDIAN       0
`define RSCL_F_BOOT_LO      1
`define RSCL_F_PCLK_LO      3
`define RSCL_F_SCLK_LO      5
`define RSCL_F_EEAUTO       7
`define RSCL_F_ATM          8
`define RSCL_F_HWIDTH       9
// status register field positions
`define RSCL_F_BOOTRSV      0
`define RSCL_F_PCLKRSV      1
`define RSCL_F_SCLKRSV      2
`define RSCL_F_EELOAD       3
`define RSCL_F_SP2EN        4
`define RSCL_F_RSVBAD       5
`define RSCL_F_CAPTURED     6
// default strap image: little endian, rom boot, dedicated clocks
`define RSCL_STRAP_RST      10'h005
`define RSCL_SWMUX_RST      32'h00000000
`define RSCL_CAPTURE_CYC    2
`endif

// ===== rtl/rscl_strap_latch.v
// reset strap configuration latch with an AHB-Lite register slave
// assumes straps are stable while rst_b is low; one clock domain
//
// The address map and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "rscl_regs.vh"
module rscl_strap_latch #(
    parameter integer CAPTURE_CYCLES = `RSCL_CAPTURE_CYC
) (
    input  wire        clk_sys,            // 50 MHz system clock
    input  wire        rst_b,              // async reset, active low
    input  wire        endian_select,      // endian strap pin
    input  wire [1:0]  boot_select,        // boot mode strap pins
    input  wire [1:0]  primary_mem_clock_select,   // primary memory clock strap
    input  wire [1:0]  secondary_mem_clock_select, // secondary memory clock strap
    input  wire        eeprom_autoinit_select,     // eeprom autoinit strap
    input  wire        atm_port_select,    // atm vs serial port 1 strap
    input  wire [2:0]  reserved_straps,    // reserved address strap lines
    input  wire        host_width_strap,   // host port width strap
    input  wire        pci_select,         // pci enable pin
    input  wire        serial_port2_select, // serial port 2 enable pin, live
    input  wire        hsel,               // ahb slave select
    input  wire [31:0] haddr,              // ahb address
    input  wire [1:0]  htrans,             // ahb transfer type
    input  wire        hwrite,             // ahb write
    input  wire [2:0]  hsize,              // ahb size
    input  wire [31:0] hwdata,             // ahb write data
    input  wire        hready,             // ahb bus ready
    output reg  [31:0] hrdata,             // ahb read data
    output reg         hreadyout,          // ahb slave ready
    output reg         hresp,              // ahb response, always okay
    output reg         bigEndian_q,        // 1 selects big endian
    output reg  [1:0]  bootMode_q,         // decoded boot mode code
    output reg         bootEnable_q,       // a supported boot is requested
    output reg  [1:0]  primaryClkSrc_q,    // 0 input clk, 1 cpu/4, 2 cpu/6
    output reg  [1:0]  secondaryClkSrc_q,  // 0 input clk, 1 cpu/4, 2 cpu/6
    output reg         pciEepromLoad_q,    // load pci config from eeprom
    output reg         serialPort1En_q,    // serial port 1 owns shared pins
    output reg         atmPortEn_q,        // atm port owns shared pins
    output reg         serialPort2En_q,    // serial port 2 enabled
    output reg         hostPort32_q,       // 32-bit host port
    output reg         hostUpperOe_q,      // upper host data lines may drive
    output reg  [31:0] swMux_q             // software pin function selects
);
    localparam [3:0] ST_RESET = 4'b0001;
    localparam [3:0] ST_SYNC  = 4'b0010;
    localparam [3:0] ST_LATCH = 4'b0100;
    localparam [3:0] ST_RUN   = 4'b1000;
    localparam integer SW = 14;

    // two-stage synchronisers; straps include reserved lines for visibility
    reg  [SW-1:0] strapMeta_q;
    reg  [SW-1:0] strapSync_q;
    reg           sp2Meta_q;
    reg           sp2Sync_q;
    wire [SW-1:0] strapPins;
    assign strapPins = {pci_select, reserved_straps, host_width_strap, atm_port_select,
                        eeprom_autoinit_select, secondary_mem_clock_select,
                        primary_mem_clock_select, boot_select, endian_select};

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            strapMeta_q <= {SW{1'b0}};
            strapSync_q <= {SW{1'b0}};
            sp2Meta_q   <= 1'b0;
            sp2Sync_q   <= 1'b0;
        end else begin
            strapMeta_q <= strapPins;
            strapSync_q <= strapMeta_q;
            sp2Meta_q   <= serial_port2_select;
            sp2Sync_q   <= sp2Meta_q;
        end
    end

    // captured image; the reset value stands until the release capture
    reg  [3:0]  state_q;
    reg  [3:0]  state_d;
    reg  [7:0]  capCnt_q;
    reg  [9:0]  strap_q;
    reg  [2:0]  rsvStrap_q;
    reg         pciSel_q;
    reg         captured_q;
    wire        doLatch;

    // reset drops straps on the floor; the copy is taken a few clocks after
    // release so only synchronised levels are stored, and never again
    always @* begin
        case (state_q)
            ST_RESET: state_d = ST_SYNC;
            ST_SYNC:  state_d = (capCnt_q >= CAPTURE_CYCLES[7:0]) ? ST_LATCH : ST_SYNC;
            ST_LATCH: state_d = ST_RUN;
            ST_RUN:   state_d = ST_RUN;
            default:  state_d = ST_RESET;
        endcase
    end
    assign doLatch = (state_q == ST_LATCH);

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_q    <= ST_RESET;
            capCnt_q   <= 8'h00;
            strap_q    <= `RSCL_STRAP_RST;
            rsvStrap_q <= 3'h0;
            pciSel_q   <= 1'b0;
            captured_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (state_q == ST_SYNC)
                capCnt_q <= capCnt_q + 8'h01;
            if (doLatch) begin
                strap_q    <= strapSync_q[9:0];
                rsvStrap_q <= strapSync_q[12:10];
                pciSel_q   <= strapSync_q[13];
                captured_q <= 1'b1;
            end
        end
    end

    // decode of the captured image
    wire       cEndian = strap_q[`RSCL_F_ENDIAN];
    wire [1:0] cBoot   = strap_q[`RSCL_F_BOOT_LO+1:`RSCL_F_BOOT_LO];
    wire [1:0] cPclk   = strap_q[`RSCL_F_PCLK_LO+1:`RSCL_F_PCLK_LO];
    wire [1:0] cSclk   = strap_q[`RSCL_F_SCLK_LO+1:`RSCL_F_SCLK_LO];
    wire       cEeAuto = strap_q[`RSCL_F_EEAUTO];
    wire       cAtm    = strap_q[`RSCL_F_ATM];
    wire       cWidth  = strap_q[`RSCL_F_HWIDTH];
    wire       sp2Live = sp2Sync_q;

    function rsv;
        input [1:0] code;
        begin
            rsv = (code == 2'b11);
        end
    endfunction

    // reserved clock codes park the field at its default, a reserved boot code passes with bootEnable_q low, others are untouched
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bigEndian_q       <= 1'b0;
            bootMode_q        <= 2'b10;
            bootEnable_q      <= 1'b0;
            primaryClkSrc_q   <= 2'b00;
            secondaryClkSrc_q <= 2'b00;
            pciEepromLoad_q   <= 1'b0;
            serialPort1En_q   <= 1'b0;
            atmPortEn_q       <= 1'b0;
            serialPort2En_q   <= 1'b0;
            hostPort32_q      <= 1'b0;
            hostUpperOe_q     <= 1'b0;
        end else begin
            bigEndian_q       <= ~cEndian;
            bootMode_q        <= cBoot;
            bootEnable_q      <= captured_q & (cBoot != 2'b00) & ~rsv(cBoot);
            primaryClkSrc_q   <= rsv(cPclk) ? 2'b00 : cPclk;
            secondaryClkSrc_q <= rsv(cSclk) ? 2'b00 : cSclk;
            // built-in defaults unless strap, pci on and port 2 off agree
            pciEepromLoad_q   <= captured_q & cEeAuto & pciSel_q & ~sp2Live;
            // one owner only for the shared serial/atm pins
            serialPort1En_q   <= captured_q & ~cAtm;
            atmPortEn_q       <= captured_q & cAtm;
            serialPort2En_q   <= captured_q & (~pciSel_q | sp2Live);
            hostPort32_q      <= cWidth;
            hostUpperOe_q     <= captured_q & cWidth;
        end
    end

    // ahb-lite slave: zero wait states, always okay
    reg        dPhase_q;
    reg        dWrite_q;
    reg [11:0] dAddr_q;
    wire       aPhase = hsel & htrans[1] & hready;
    wire       badBoot = rsv(cBoot) | rsv(cPclk) | rsv(cSclk);
    wire [31:0] statusWord;
    assign statusWord = {25'h0, captured_q, (rsvStrap_q != 3'b011),
                         serialPort2En_q, pciEepromLoad_q, rsv(cSclk),
                         rsv(cPclk), rsv(cBoot)};

    function [31:0] readMux;
        input [11:0] a;
        input [9:0]  strap;
        input [31:0] stat;
        input [31:0] mux;
        input [3:0]  pins;
        begin
            case (a)
                `RSCL_OFF_STRAP:  readMux = {22'h0, strap};
                `RSCL_OFF_PINSEL: readMux = {28'h0000000, pins};
                `RSCL_OFF_STATUS: readMux = stat;
                `RSCL_OFF_SWMUX:  readMux = mux;
                default:          readMux = 32'h00000000;
            endcase
        end
    endfunction

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            dPhase_q  <= 1'b0;
            dWrite_q  <= 1'b0;
            dAddr_q   <= 12'h000;
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            swMux_q   <= `RSCL_SWMUX_RST;
        end else begin
            dPhase_q <= aPhase;
            dWrite_q <= aPhase & hwrite;
            if (aPhase)
                dAddr_q <= {haddr[11:2], 2'b00};
            if (aPhase & ~hwrite)
                hrdata <= readMux({haddr[11:2], 2'b00}, strap_q, statusWord, swMux_q,
                                  {serialPort2En_q, pciSel_q, badBoot, captured_q});
            // only the software select register is writable, at any time
            if (dPhase_q & dWrite_q & (dAddr_q == `RSCL_OFF_SWMUX))
                swMux_q <= hwdata;
        end
    end
endmodule // rscl_strap_latch
`default_nettype wire
